//--- vai_defs.svh
// Purpose: Named constants for the VME arbiter and interrupt handler
// Assumes: Included by bare name from the design files
// Notes:   Window bounds are upper 16 address bits (64KB units)
`ifndef VAI_DEFS_SVH
`define VAI_DEFS_SVH

`define VAI_NLEV         7
`define VAI_VEC_W        8
`define VAI_CFG_PRIO_BIT 0
`define VAI_CFG_REL_BIT  1
`define VAI_CFG_RESET    2'h1
`define VAI_SEL_ARB      1'b0
`define VAI_SEL_A32      1'b1
`define VAI_IO_CPU_BASE  16'h8000
`define VAI_IO_PCI_OFS   16'h8000
`define VAI_MEM_CPU_BASE 16'hA000
`define VAI_MEM_PCI_OFS  16'hA000
`define VAI_A32_RESET    16'hC000
`define VAI_A32_PCI_OFS  16'hA000
`define VAI_A32_CPU_LAST 16'hFAFF

`endif

//--- vai_pkg.sv
// Purpose: Types shared by the VME arbiter and interrupt handler
// Assumes: Nothing beyond the language
// Notes:   State codes are one-hot
`default_nettype none
package vai_pkg;
    typedef enum logic [1:0] {
        VAI_SP_NONE = 2'h0,
        VAI_SP_IO   = 2'h1,
        VAI_SP_MEM  = 2'h2,
        VAI_SP_A32  = 2'h3
    } vai_space_t;

    typedef enum logic [3:0] {
        VAI_A_IDLE  = 4'h1,
        VAI_A_GRANT = 4'h2,
        VAI_A_SLOT  = 4'h4,
        VAI_A_OWN   = 4'h8
    } vai_arb_t;

    typedef enum logic [4:0] {
        VAI_I_IDLE = 5'h01,
        VAI_I_WAIT = 5'h02,
        VAI_I_ADDR = 5'h04,
        VAI_I_ACK  = 5'h08,
        VAI_I_REL  = 5'h10
    } vai_iack_t;
endpackage
`default_nettype wire

//--- vai_pick.sv
// Purpose: Fixed-priority picker, lowest index wins
// Assumes: Purely combinational
// Notes:   Priority comes from structure only, nothing programmable
`default_nettype none
module vai_pick #(
    parameter int N = 8
) (
    input  wire logic [N-1:0]         req_i,
    output logic                      any_o,
    output logic [N-1:0]              onehot_o,
    output logic [$clog2(N+1)-1:0]    idx_o
);
    initial begin
        if (N < 2) $error("vai_pick needs at least two inputs");
    end

    always_comb begin
        onehot_o = '0;
        idx_o    = '0;
        any_o    = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                onehot_o = '0;
                onehot_o[i] = 1'b1;
                idx_o    = ($clog2(N+1))'(i);
                any_o    = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- vai_top.sv
// Purpose: VME system controller: bus arbiter, interrupt handler, PCI decode
// Assumes: One 125 MHz clock, synchronous active-high reset
// Notes:   Bus control pins pass a three-flop filter before use; data lines are sampled unfiltered
//
// Behaviour
// - Reset default is fixed lowest-slot priority
// - Fixed priority and release-on-request, combinable
// - Arbitration config register, processor read/write
// - Watch seven active-low interrupt request lines
// - Level seven highest, level one lowest
// - Same level: lowest slot served first
// - Priorities fixed by hardware structure
// - Route request to processor, accept acknowledge
// - Win mastership first unless already held
// - Acknowledge cycle drives level on A03-A01
// - Level valid at acknowledge falling edge
// - Acknowledge daisy chain starts lowest slot
// - Vector handed to processor unchanged
// - Decode windows on 64KB granularity
// - Default I/O and memory window translation
// - Reprogrammable A32 window, resizes memory
`include "vai_defs.svh"
`default_nettype none
module vai_top
    import vai_pkg::*;
#(
    parameter int NSLOT = 8
) (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    cfg_wr_i,
    input  wire logic                    cfg_sel_i,
    input  wire logic [15:0]             cfg_wdata_i,
    output logic [15:0]                  cfg_rdata_o,
    input  wire logic                    cpu_bus_req_i,
    output logic                         cpu_bus_own_o,
    input  wire logic [NSLOT-1:0]        slot_is_cpu_i,
    input  wire logic [NSLOT-1:0]        bus_req_n_i,
    output logic [NSLOT-1:0]             bus_grant_n_o,
    input  wire logic                    bbsy_n_i,
    output logic                         bbsy_o,
    output logic                         bbsy_oe_o,
    input  wire logic [`VAI_NLEV:1]      irq_n_i,
    output logic                         irq_pend_o,
    output logic [2:0]                   irq_level_o,
    input  wire logic                    cpu_iack_i,
    output logic                         iack_n_o,
    output logic                         iack_chain_n_o,
    output logic [3:1]                   vme_addr_o,
    output logic                         vme_addr_oe_o,
    input  wire logic                    dtack_n_i,
    input  wire logic [`VAI_VEC_W-1:0]   vme_data_i,
    output logic [`VAI_VEC_W-1:0]        vector_o,
    output logic                         vector_valid_o,
    input  wire logic [31:0]             cpu_addr_i,
    output logic [31:0]                  pci_addr_o,
    output vai_space_t                   space_o
);
    localparam int NIN = NSLOT + `VAI_NLEV + 2;

    initial begin
        if (NSLOT < 2 || NSLOT > 21) $error("NSLOT must be 2 to 21");
    end

    // Pin filter: change accepted once flops two and three agree
    logic [NIN-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [NIN-1:0] pins;
    assign pins = {dtack_n_i, bbsy_n_i, irq_n_i, bus_req_n_i};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            filt_reg <= '1;
        end else begin
            for (int i = 0; i < NIN; i++) begin
                if (s2_reg[i] == s3_reg[i]) filt_reg[i] <= s3_reg[i];
            end
        end
    end

    logic [NSLOT-1:0]     slot_req;
    logic [`VAI_NLEV:1]   irq_act;
    logic                 bbsy_seen;
    logic                 dtack_seen;
    assign slot_req   = ~filt_reg[NSLOT-1:0] & ~slot_is_cpu_i;
    assign irq_act    = ~filt_reg[NSLOT +: `VAI_NLEV];
    assign bbsy_seen  = ~filt_reg[NIN-2];
    assign dtack_seen = ~filt_reg[NIN-1];

    // Configuration registers
    logic [1:0]  arb_cfg_reg;
    logic [15:0] a32_base_reg;
    logic        prio_en, rel_en;
    assign prio_en = arb_cfg_reg[`VAI_CFG_PRIO_BIT];
    assign rel_en  = arb_cfg_reg[`VAI_CFG_REL_BIT];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            arb_cfg_reg <= `VAI_CFG_RESET;
        end else if (cfg_wr_i && cfg_sel_i == `VAI_SEL_ARB) begin
            arb_cfg_reg <= cfg_wdata_i[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            a32_base_reg <= `VAI_A32_RESET;
        end else if (cfg_wr_i && cfg_sel_i == `VAI_SEL_A32) begin
            a32_base_reg <= cfg_wdata_i;
        end
    end

    assign cfg_rdata_o = (cfg_sel_i == `VAI_SEL_A32) ? a32_base_reg
                                                     : {14'h0000, arb_cfg_reg};

    logic [NSLOT-1:0] slot_hot;
    logic             slot_any;
    vai_pick #(.N(NSLOT)) u_slot_pick (
        .req_i    (slot_req),
        .any_o    (slot_any),
        .onehot_o (slot_hot),
        .idx_o    ()
    );

    logic [`VAI_NLEV-1:0] lev_rev;
    logic [2:0]           lev_idx;
    logic                 lev_any;
    always_comb begin
        for (int i = 0; i < `VAI_NLEV; i++) lev_rev[i] = irq_act[`VAI_NLEV - i];
    end
    vai_pick #(.N(`VAI_NLEV)) u_lev_pick (
        .req_i    (lev_rev),
        .any_o    (lev_any),
        .onehot_o (),
        .idx_o    (lev_idx)
    );
    logic [2:0] lev_win;
    assign lev_win = 3'(`VAI_NLEV) - lev_idx;

    assign irq_pend_o  = lev_any;
    assign irq_level_o = lev_any ? lev_win : 3'h0;

    vai_arb_t  arb_reg;
    vai_iack_t iack_reg;
    logic [NSLOT-1:0] grant_reg;
    logic             own_req;
    logic             slot_first;
    assign own_req = cpu_bus_req_i || (iack_reg != VAI_I_IDLE);
    // slots first under fixed priority or release
    assign slot_first = slot_any && (prio_en || rel_en || !own_req);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            arb_reg   <= VAI_A_IDLE;
            grant_reg <= '0;
        end else begin
            case (arb_reg)
                VAI_A_IDLE: begin
                    if (slot_first && !bbsy_seen) begin
                        grant_reg <= slot_hot;
                        arb_reg   <= VAI_A_GRANT;
                    end else if (own_req && !bbsy_seen) begin
                        arb_reg <= VAI_A_OWN;
                    end
                end
                VAI_A_GRANT: begin
                    if (bbsy_seen) begin
                        grant_reg <= '0;
                        arb_reg   <= VAI_A_SLOT;
                    end
                end
                VAI_A_SLOT: begin
                    if (!bbsy_seen) arb_reg <= VAI_A_IDLE;
                end
                VAI_A_OWN: begin
                    if (!own_req) begin
                        arb_reg <= VAI_A_IDLE;
                    end else if (rel_en && slot_any && iack_reg == VAI_I_IDLE) begin
                        arb_reg <= VAI_A_IDLE;
                    end
                end
                default: begin
                    arb_reg   <= VAI_A_IDLE;
                    grant_reg <= '0;
                end
            endcase
        end
    end

    assign bus_grant_n_o = ~grant_reg;
    assign cpu_bus_own_o = (arb_reg == VAI_A_OWN);
    // Open drain: pulled low while tenure held
    assign bbsy_o    = 1'b0;
    assign bbsy_oe_o = (arb_reg != VAI_A_OWN);

    // Acknowledge cycle
    logic [2:0] ack_lev_reg;
    logic       iack_n_reg;
    logic       addr_drv_reg;
    logic [`VAI_VEC_W-1:0] vec_reg;
    logic       vec_vld_reg;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            iack_reg     <= VAI_I_IDLE;
            ack_lev_reg  <= 3'h0;
            iack_n_reg   <= 1'b1;
            addr_drv_reg <= 1'b0;
        end else begin
            case (iack_reg)
                VAI_I_IDLE: begin
                    if (cpu_iack_i && lev_any) begin
                        ack_lev_reg <= lev_win;
                        iack_reg    <= VAI_I_WAIT;
                    end
                end
                VAI_I_WAIT: begin
                    if (arb_reg == VAI_A_OWN) begin
                        addr_drv_reg <= 1'b1;
                        iack_reg     <= VAI_I_ADDR;
                    end
                end
                // level settles a cycle before falling edge
                VAI_I_ADDR: begin
                    iack_n_reg <= 1'b0;
                    iack_reg   <= VAI_I_ACK;
                end
                VAI_I_ACK: begin
                    if (dtack_seen) begin
                        iack_n_reg   <= 1'b1;
                        addr_drv_reg <= 1'b0;
                        iack_reg     <= VAI_I_REL;
                    end
                end
                VAI_I_REL: begin
                    if (!dtack_seen) iack_reg <= VAI_I_IDLE;
                end
                default: begin
                    iack_reg     <= VAI_I_IDLE;
                    iack_n_reg   <= 1'b1;
                    addr_drv_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            vec_reg     <= '0;
            vec_vld_reg <= 1'b0;
        end else begin
            vec_vld_reg <= 1'b0;
            if (iack_reg == VAI_I_ACK && dtack_seen) begin
                vec_reg     <= vme_data_i;
                vec_vld_reg <= 1'b1;
            end
        end
    end

    // level on A03-A01 with IACK low
    // chain entry is the lowest slot
    assign iack_n_o       = iack_n_reg;
    assign iack_chain_n_o = iack_n_reg;
    assign vme_addr_o     = ack_lev_reg;
    assign vme_addr_oe_o  = !addr_drv_reg;
    assign vector_o       = vec_reg;
    assign vector_valid_o = vec_vld_reg;

    // decode on upper 16 bits only
    logic [15:0] up;
    assign up = cpu_addr_i[31:16];

    // window translation; memory ends at A32 base
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pci_addr_o <= '0;
            space_o    <= VAI_SP_NONE;
        end else if (up >= a32_base_reg && up <= `VAI_A32_CPU_LAST) begin
            pci_addr_o <= {up - `VAI_A32_PCI_OFS, cpu_addr_i[15:0]};
            space_o    <= VAI_SP_A32;
        end else if (up >= `VAI_MEM_CPU_BASE && up < a32_base_reg) begin
            pci_addr_o <= {up - `VAI_MEM_PCI_OFS, cpu_addr_i[15:0]};
            space_o    <= VAI_SP_MEM;
        end else if (up >= `VAI_IO_CPU_BASE && up < `VAI_MEM_CPU_BASE) begin
            pci_addr_o <= {up - `VAI_IO_PCI_OFS, cpu_addr_i[15:0]};
            space_o    <= VAI_SP_IO;
        end else begin
            pci_addr_o <= '0;
            space_o    <= VAI_SP_NONE;
        end
    end

    // Checks
    a_reset_cfg: assert property (@(posedge clock_i)
        $fell(rst_i) |-> arb_cfg_reg == `VAI_CFG_RESET)
        else $error("config reset value wrong");
    a_grant_lowest: assert property (@(posedge clock_i) disable iff (rst_i)
        (arb_reg == VAI_A_IDLE && slot_any && prio_en && !bbsy_seen)
        |=> grant_reg == $past(slot_hot))
        else $error("grant not lowest slot");
    a_grant_one: assert property (@(posedge clock_i) disable iff (rst_i)
        $onehot0(grant_reg) && !(cpu_bus_own_o && grant_reg != '0))
        else $error("multiple grants");
    a_level_top: assert property (@(posedge clock_i) disable iff (rst_i)
        irq_act[`VAI_NLEV] |-> irq_level_o == 3'h7)
        else $error("level seven not chosen");
    a_level_low: assert property (@(posedge clock_i) disable iff (rst_i)
        (irq_act == 7'h01) |-> irq_level_o == 3'h1)
        else $error("level one not chosen");
    a_iack_owner: assert property (@(posedge clock_i) disable iff (rst_i)
        !iack_n_o |-> cpu_bus_own_o)
        else $error("acknowledge without mastership");
    a_addr_before: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(iack_n_o) |-> !vme_addr_oe_o && !$past(vme_addr_oe_o)
        && vme_addr_o == $past(vme_addr_o))
        else $error("level not settled at falling edge");
    a_vec_pass: assert property (@(posedge clock_i) disable iff (rst_i)
        (iack_reg == VAI_I_ACK && dtack_seen) |=> vector_valid_o
        && vector_o == $past(vme_data_i) ##1 !vector_valid_o)
        else $error("vector altered or not one pulse");
    a_win_io: assert property (@(posedge clock_i) disable iff (rst_i)
        (cpu_addr_i == 32'h8000_0000) |=> space_o == VAI_SP_IO
        && pci_addr_o == 32'h0000_0000)
        else $error("io window wrong");

    c_slot_grant: cover property (@(posedge clock_i) disable iff (rst_i)
        arb_reg == VAI_A_GRANT ##[1:20] arb_reg == VAI_A_SLOT);
    c_iack_done: cover property (@(posedge clock_i) disable iff (rst_i)
        vector_valid_o);
    c_release: cover property (@(posedge clock_i) disable iff (rst_i)
        arb_reg == VAI_A_OWN && rel_en && slot_any ##1 arb_reg == VAI_A_IDLE);
endmodule
`default_nettype wire

//--- vai_vme_model.sv
// Purpose: Backplane boards: one interrupter per level, bus masters per slot
// Assumes: Bench raises requests with one-cycle pulses
// Notes:   Undriven data lines toggle every cycle except at the acknowledge edge and during the reply delay
`default_nettype none
module vai_vme_model #(
    parameter int NSLOT = 8
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic [7:1]        irq_set_i,
    input  wire logic [7:1][7:0]   vec_i,
    input  wire logic [3:0]        delay_i,
    input  wire logic [NSLOT-1:0]  slot_req_i,
    input  wire logic              iack_n_i,
    input  wire logic [3:1]        addr_i,
    input  wire logic [NSLOT-1:0]  grant_n_i,
    output logic [7:1]             irq_n_o,
    output logic                   dtack_n_o,
    output logic [7:0]             data_o,
    output logic [NSLOT-1:0]       bus_req_n_o,
    output logic                   bbsy_n_o,
    output logic [2:0]             seen_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       iack_q;
    logic       busy;
    logic [3:0] cnt;
    logic [4:0] hold;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_n_o <= '1;
            dtack_n_o <= 1'b1;
            data_o <= 8'h5a;
            busy <= 1'b0;
            iack_q <= 1'b1;
            seen_lvl_o <= 3'h0;
            cnt <= 4'h0;
        end else begin
            iack_q <= iack_n_i;
            irq_n_o <= irq_n_o & ~irq_set_i;
            // level sampled at falling edge, claim own level only
            if (iack_q && !iack_n_i) begin
                seen_lvl_o <= addr_i;
                busy <= !irq_n_o[addr_i];
                cnt <= delay_i;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                dtack_n_o <= 1'b0;
                data_o <= vec_i[seen_lvl_o];
                irq_n_o[seen_lvl_o] <= 1'b1;
                busy <= 1'b0;
            end else if (dtack_n_o || iack_n_i) begin
                dtack_n_o <= 1'b1;
                data_o <= ~data_o;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bus_req_n_o <= '1;
            bbsy_n_o <= 1'b1;
            hold <= 5'h00;
        end else if (hold != 5'h00) begin
            bus_req_n_o <= bus_req_n_o & ~slot_req_i;
            hold <= hold - 5'h01;
            bbsy_n_o <= (hold == 5'h01);
        end else if (grant_n_i != '1 && bbsy_n_o) begin
            bus_req_n_o <= (bus_req_n_o & ~slot_req_i) | ~grant_n_i;
            hold <= 5'h14;
            bbsy_n_o <= 1'b0;
        end else begin
            bus_req_n_o <= bus_req_n_o & ~slot_req_i;
        end
    end
endmodule
`default_nettype wire

//--- vai_top_tb.sv
// Purpose: Self-checking bench for the VME system controller
// Assumes: Board model on the far side, 125 MHz clock
// Notes:   Open-drain busy wire resolved here from both drivers
`default_nettype none
module vai_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vai_pkg::*;
    localparam int NS = 8;
    logic              clock_i = 0, rst_i = 1, cfg_wr = 0, cfg_sel = 0, cpu_req = 0, cpu_iack = 0;
    logic [15:0]       cfg_wdata = 16'h0000, rdata, base = 16'hC000;
    logic [NS-1:0]     is_cpu = '0, slot_req = '0, grant_n, req_n;
    logic [7:1]        irq_set = '0, irq_n;
    logic [7:1][7:0]   vec = '0;
    logic [31:0]       cpu_addr = 32'h0000_0000, pci;
    logic [3:0]        dly = 4'h0;
    logic              own, bbsy_o, bbsy_oe, pend, iack_n, chain_n, aoe, vvalid, dtack_n, bbsy_m;
    logic [2:0]        lvl, seen;
    logic [3:1]        vaddr;
    logic [7:0]        data, vector;
    vai_space_t        space;
    integer            seed = 32'h70f8_09f1, failures = 0, checks_done = 0, cycles = 0;
    wire logic         bbsy_w = bbsy_m & (bbsy_oe | bbsy_o);

    always #4 clock_i = ~clock_i;

    vai_top #(.NSLOT(NS)) vai_top_inst (
        .clock_i(clock_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr), .cfg_sel_i(cfg_sel),
        .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(rdata), .cpu_bus_req_i(cpu_req),
        .cpu_bus_own_o(own), .slot_is_cpu_i(is_cpu), .bus_req_n_i(req_n),
        .bus_grant_n_o(grant_n), .bbsy_n_i(bbsy_w), .bbsy_o(bbsy_o), .bbsy_oe_o(bbsy_oe),
        .irq_n_i(irq_n), .irq_pend_o(pend), .irq_level_o(lvl), .cpu_iack_i(cpu_iack),
        .iack_n_o(iack_n), .iack_chain_n_o(chain_n), .vme_addr_o(vaddr),
        .vme_addr_oe_o(aoe), .dtack_n_i(dtack_n), .vme_data_i(data), .vector_o(vector),
        .vector_valid_o(vvalid), .cpu_addr_i(cpu_addr), .pci_addr_o(pci), .space_o(space));

    vai_vme_model #(.NSLOT(NS)) vai_vme_model_inst (
        .clock_i(clock_i), .rst_i(rst_i), .irq_set_i(irq_set), .vec_i(vec), .delay_i(dly),
        .slot_req_i(slot_req), .iack_n_i(iack_n), .addr_i(vaddr), .grant_n_i(grant_n),
        .irq_n_o(irq_n), .dtack_n_o(dtack_n), .data_o(data), .bus_req_n_o(req_n),
        .bbsy_n_o(bbsy_m), .seen_lvl_o(seen));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_sp(input vai_space_t got, input vai_space_t exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: space got %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic done_test(input string n);
        $display("test %s finished, failures so far %0d", n, failures);
    endtask

    function automatic vai_space_t exp_sp(input logic [31:0] a, input logic [15:0] b);
        if (a[31:16] >= 16'h8000 && a[31:16] <= 16'h9FFF) return VAI_SP_IO;
        if (a[31:16] >= 16'hA000 && a[31:16] < b) return VAI_SP_MEM;
        if (a[31:16] >= b && a[31:16] <= 16'hFAFF) return VAI_SP_A32;
        return VAI_SP_NONE;
    endfunction

    task automatic cfgw(input logic sel, input logic [15:0] d);
        @(posedge clock_i);
        cfg_wr <= 1'b1;
        cfg_sel <= sel;
        cfg_wdata <= d;
        @(posedge clock_i);
        cfg_wr <= 1'b0;
    endtask

    task automatic cfgr(input logic sel, input logic [15:0] exp);
        @(posedge clock_i);
        cfg_sel <= sel;
        @(negedge clock_i);
        cmp(rdata, exp, "config readback");
    endtask

    task automatic dec(input logic [31:0] a);
        vai_space_t e;
        @(posedge clock_i);
        cpu_addr <= a;
        @(posedge clock_i);
        #1;
        e = exp_sp(a, base);
        cmp_sp(space, e);
        if (e != VAI_SP_NONE) begin
            cmp(pci, a - ((e == VAI_SP_IO) ? 32'h8000_0000 : 32'hA000_0000), "pci");
        end
    endtask

    task automatic grant_is(input int s);
        logic [NS-1:0] g;
        repeat (300) begin @(negedge clock_i); if (grant_n !== '1) break; end
        g = ~grant_n;
        cmp(32'(g), 32'h0000_0001 << s, "grant");
        repeat (300) begin @(negedge clock_i); if (bbsy_w === 1'b0) break; end
        repeat (300) begin @(negedge clock_i); if (bbsy_w === 1'b1 && grant_n === '1) break; end
    endtask

    task automatic wait_own;
        repeat (300) begin @(negedge clock_i); if (own === 1'b1) break; end
    endtask

    task automatic irq_run(input logic [7:1] m);
        @(posedge clock_i);
        for (int l = 1; l <= 7; l++) vec[l] <= 8'($random(seed));
        irq_set <= m;
        @(posedge clock_i);
        irq_set <= '0;
        repeat (6) @(posedge clock_i);
        for (int l = 7; l >= 1; l--) begin
            if (m[l]) begin
                @(negedge clock_i);
                cmp(lvl, l, "level");
                cmp(pend, 1, "pending");
                @(posedge clock_i);
                cpu_iack <= 1'b1;
                dly <= 4'($random(seed));
                @(posedge clock_i);
                cpu_iack <= 1'b0;
                repeat (300) begin @(negedge clock_i); if (vvalid === 1'b1) break; end
                cmp(vvalid, 1, "vector strobe");
                cmp(vector, vec[l], "vector");
                cmp(seen, l, "acknowledged level");
                cmp(vaddr, l, "level on address");
                repeat (300) begin
                    @(negedge clock_i);
                    if (dtack_n === 1'b1 && iack_n === 1'b1) break;
                end
                repeat (6) @(posedge clock_i);
            end
        end
        @(negedge clock_i);
        cmp(pend, 0, "pending after service");
        done_test("interrupt");
    endtask

    always @(negedge clock_i) begin
        if (!rst_i && iack_n === 1'b0) begin
            cmp(own, 1, "owner during ack");
            cmp(chain_n, 0, "chain start");
            cmp(aoe, 0, "address driven");
            cmp({bbsy_oe, bbsy_o}, 0, "busy driven");
        end
    end

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            $display("unexpected at %0t: run did not finish", $time);
            final_report;
        end
    end

    initial begin
        logic [31:0] corner [9];
        logic [NS-1:0] m;
        corner = '{32'h8000_0000, 32'h9FFF_FFFF, 32'hA000_0000, 32'hBFFF_FFFF, 32'hC000_0000,
                   32'hFAFF_FFFF, 32'hFB00_0000, 32'h7FFF_FFFF, 32'hFFFF_FFFF};
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        cfgr(1'b0, 16'h0001);
        cfgr(1'b1, 16'hC000);
        cmp_sp(space, VAI_SP_NONE);
        cmp(grant_n, 8'hFF, "grants idle");
        done_test("reset");
        for (int i = 0; i < 4; i++) begin
            cfgw(1'b0, 16'(i));
            cfgr(1'b0, 16'(i));
        end
        cfgw(1'b0, 16'h0001);
        done_test("config");
        foreach (corner[i]) dec(corner[i]);
        repeat (40) dec($random(seed));
        cfgw(1'b1, 16'hD000);
        base = 16'hD000;
        cfgr(1'b1, 16'hD000);
        dec(32'hC000_1234);
        dec(32'hD000_0000);
        repeat (20) dec($random(seed));
        done_test("decode");
        @(posedge clock_i);
        is_cpu <= 8'h02;
        slot_req <= 8'h22;
        @(posedge clock_i);
        slot_req <= '0;
        grant_is(5);
        @(posedge clock_i);
        is_cpu <= '0;
        grant_is(1);
        repeat (4) begin
            m = 8'($random(seed));
            @(posedge clock_i);
            slot_req <= m;
            @(posedge clock_i);
            slot_req <= '0;
            for (int s = 0; s < NS; s++) if (m[s]) grant_is(s);
        end
        done_test("fixed priority");
        for (int k = 2; k <= 3; k++) begin
            cfgw(1'b0, 16'(k));
            cpu_req <= 1'b1;
            wait_own();
            cmp(own, 1, "processor owns");
            @(posedge clock_i);
            slot_req <= 8'h10;
            @(posedge clock_i);
            slot_req <= '0;
            grant_is(4);
            wait_own();
        end
        cfgw(1'b0, 16'h0001);
        slot_req <= 8'h08;
        @(posedge clock_i);
        slot_req <= '0;
        repeat (40) @(posedge clock_i);
        @(negedge clock_i);
        cmp(own, 1, "no release");
        @(posedge clock_i);
        cpu_req <= 1'b0;
        grant_is(3);
        done_test("release on request");
        irq_run(7'h24);
        irq_run(7'h7F);
        repeat (3) irq_run(7'($random(seed)) | 7'h01);
        final_report;
    end
endmodule
`default_nettype wire
